// File: oss_pkg.sv
// shared constants and types for operand size and segment selection
package oss_pkg;

  // effective operand and address widths
  typedef enum logic [1:0] {OSS_SZ16, OSS_SZ32, OSS_SZ64} oss_size_e;

  // segment registers, ordered as the override encoding
  typedef enum logic [2:0] {
    OSS_SEG_EXTRA,
    OSS_SEG_CODE,
    OSS_SEG_STACK,
    OSS_SEG_DATA,
    OSS_SEG_AUX1,
    OSS_SEG_AUX2
  } oss_seg_e;

  // kind of memory reference being made
  typedef enum logic [1:0] {
    OSS_REF_FETCH,
    OSS_REF_STACK_OP,
    OSS_REF_DATA,
    OSS_REF_STR_DST
  } oss_ref_e;

  localparam int OSS_NUM_SEG = 6;
  localparam int OSS_SEG_W = 3;

  // register map, byte addresses
  localparam logic [7:0] OSS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OSS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] OSS_ADDR_COUNT = 8'h08;
  localparam logic [7:0] OSS_ADDR_BASE0 = 8'h10;
  localparam logic [7:0] OSS_ADDR_BASE_END = 8'h40;
  localparam logic [31:0] OSS_CTRL_RST = 32'h0000_0000;

  // control fields
  localparam int OSS_CTRL_LMA = 0;
  localparam int OSS_CTRL_L = 1;
  localparam int OSS_CTRL_D = 2;
  localparam int OSS_CTRL_PE = 3;
  localparam int OSS_CTRL_W = 4;

  // register-extension prefix nibble fields
  localparam int OSS_OPERAND_WIDTH_BIT_BIT = 3;

  // axi responses
  localparam logic [1:0] OSS_RESP_OKAY = 2'b00;
  localparam logic [1:0] OSS_RESP_SLVERR = 2'b10;

endpackage : oss_pkg

// File: oss_size_decode.sv
// effective operand and address size decode
`timescale 1ns/1ps
`default_nettype none
module oss_size_decode (
  input wire logic mode64,
  input wire logic prot_en,
  input wire logic cs_d,
  input wire logic has_opsz,
  input wire logic has_adsz,
  input wire logic rex_present,
  input wire logic [3:0] rex_bits,
  input wire logic media_op,
  output oss_pkg::oss_size_e op_size,
  output oss_pkg::oss_size_e adr_size,
  output logic [3:0] rex_fields
);
  logic w;
  logic dflt32;

  // size table for 64-bit and legacy code segments
  always_comb begin
    rex_fields = rex_present ? rex_bits : 4'h0;
    w = rex_fields[oss_pkg::OSS_OPERAND_WIDTH_BIT_BIT];
    dflt32 = prot_en & cs_d; // real mode always 16
    if (mode64) begin
      // no 16-bit addressing here
      adr_size = has_adsz ? oss_pkg::OSS_SZ32 : oss_pkg::OSS_SZ64;
      if (w) begin
        op_size = oss_pkg::OSS_SZ64; // width bit wins
      end else if (has_opsz && !media_op) begin
        op_size = oss_pkg::OSS_SZ16;
      end else begin
        op_size = oss_pkg::OSS_SZ32;
      end
    end else begin
      // compatibility behaves as legacy protected
      op_size = (dflt32 ^ has_opsz) ? oss_pkg::OSS_SZ32 : oss_pkg::OSS_SZ16;
      adr_size = (dflt32 ^ has_adsz) ? oss_pkg::OSS_SZ32 : oss_pkg::OSS_SZ16;
    end
  end
endmodule : oss_size_decode
`default_nettype wire

// File: oss_seg_select.sv
// segment choice and segment base for one memory reference
`timescale 1ns/1ps
`default_nettype none
module oss_seg_select (
  input wire logic mode64,
  input wire oss_pkg::oss_ref_e ref_kind,
  input wire logic base_sp_bp,
  input wire logic ovr_valid,
  input wire logic [2:0] ovr_seg,
  input wire logic [5:0][63:0] bases,
  output oss_pkg::oss_seg_e seg,
  output logic [63:0] seg_base
);
  logic ovr_ok;

  // fixed segments first; override only moves plain data refs
  always_comb begin
    ovr_ok = ovr_valid && (ovr_seg < 3'(oss_pkg::OSS_NUM_SEG));
    case (ref_kind)
      oss_pkg::OSS_REF_FETCH: seg = oss_pkg::OSS_SEG_CODE;
      oss_pkg::OSS_REF_STACK_OP: seg = oss_pkg::OSS_SEG_STACK;
      oss_pkg::OSS_REF_STR_DST: seg = oss_pkg::OSS_SEG_EXTRA;
      default: begin
        if (ovr_ok) begin
          seg = oss_pkg::oss_seg_e'(ovr_seg);
        end else if (base_sp_bp) begin
          seg = oss_pkg::OSS_SEG_STACK;
        end else begin
          seg = oss_pkg::OSS_SEG_DATA;
        end
      end
    endcase
    // flat model in 64-bit mode except the two aux segments
    if (mode64 && seg != oss_pkg::OSS_SEG_AUX1 && seg != oss_pkg::OSS_SEG_AUX2) begin
      seg_base = 64'h0;
    end else begin
      seg_base = bases[seg];
    end
  end
endmodule : oss_seg_select
`default_nettype wire

// File: oss_decode_top.sv
// operand size, address size and segment decode stage with axi4-lite registers
// Summary of operation
// - 64-bit mode defaults: 64 address, 32 operand
// - long flag set with long mode active selects 64-bit table
// - 64-bit mode: prefix 67 gives 32 address
// - address and operand overrides decode independently
// - 64-bit mode: width bit gives 64-bit operands
// - 64-bit mode: prefix 66 alone gives 16-bit operands
// - 64-bit mode: width bit beats prefix 66
// - extension prefix is four field bits
// - 64-bit mode: mandatory 66 media ops ignore prefix 66 for operand size
// - immediates allowed except divides, max 32 bits
// - pair: high half data-high, low accumulator
// - new low-byte registers need extension prefix
// - wide data-high:accumulator form 128-bit operand
// - offsets 16/32 legacy, 32/64 in 64-bit
// - fetches always use code segment
// - stack or frame base defaults stack
// - pushes and pops always use stack segment
// - data defaults data segment, prefix overrides
// - string destination always extra segment
// - far pointer: offset dword, then selector word
// - 64-bit mode: main segment bases zero
// - 64-bit mode: aux segment bases kept
// - compatibility mode segments act as legacy
// - legacy default size from default-size flag
`timescale 1ns/1ps
`default_nettype none
module oss_decode_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // instruction from prefix decode
  input wire logic in_valid,
  input wire logic has_opsz,
  input wire logic has_adsz,
  input wire logic rex_present,
  input wire logic [3:0] rex_bits,
  input wire logic media_op,
  input wire oss_pkg::oss_ref_e ref_kind,
  input wire logic base_sp_bp,
  input wire logic ovr_valid,
  input wire logic [2:0] ovr_seg,
  input wire logic [63:0] eff_addr,
  input wire logic imm_valid,
  input wire logic op_is_divide,
  input wire logic [31:0] imm,
  input wire logic [63:0] accumulator_register_wide,
  input wire logic [63:0] data_high_register_wide,
  input wire logic [47:0] far_ptr,
  input wire logic [3:0] byte_reg,
  // decoded results
  output logic out_valid,
  output oss_pkg::oss_size_e op_size,
  output oss_pkg::oss_size_e adr_size,
  output logic [3:0] rex_fields,
  output oss_pkg::oss_seg_e seg,
  output logic [63:0] linear_addr,
  output logic [63:0] imm_ext,
  output logic imm_bad,
  output logic [127:0] pair_operand,
  output logic [31:0] far_offset,
  output logic [15:0] far_selector,
  output logic [3:0] byte_idx,
  output logic byte_hi,
  output logic byte_bad
);

  typedef struct packed {
    // bus slave state
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // registers
    logic [31:0] ctrl;
    logic [5:0][63:0] base;
    logic [31:0] count;

    // last results
    logic out_valid;
    oss_pkg::oss_size_e op_size;
    oss_pkg::oss_size_e adr_size;
    logic [3:0] rex_fields;
    oss_pkg::oss_seg_e seg;
    logic [63:0] linear;
    logic [63:0] imm_ext;
    logic imm_bad;
    logic [127:0] pair;
    logic [31:0] far_ofs;
    logic [15:0] far_sel;
    logic [3:0] byte_idx;
    logic byte_hi;
    logic byte_bad;
  } oss_state_s;

  oss_state_s st_r;
  oss_state_s st_nxt;

  logic mode64;
  logic prot_en;

  oss_pkg::oss_size_e dec_op;
  oss_pkg::oss_size_e dec_adr;
  logic [3:0] dec_rex;
  oss_pkg::oss_seg_e dec_seg;
  logic [63:0] dec_base;
  logic [63:0] ea_m;
  logic [63:0] lin;

  // 64-bit mode needs long mode active and the long flag of code segment
  assign mode64 = st_r.ctrl[oss_pkg::OSS_CTRL_LMA] & st_r.ctrl[oss_pkg::OSS_CTRL_L];
  assign prot_en = st_r.ctrl[oss_pkg::OSS_CTRL_PE];

  oss_size_decode u_size (
    .mode64(mode64),
    .prot_en(prot_en),
    .cs_d(st_r.ctrl[oss_pkg::OSS_CTRL_D]),
    .has_opsz(has_opsz),
    .has_adsz(has_adsz),
    .rex_present(rex_present),
    .rex_bits(rex_bits),
    .media_op(media_op),
    .op_size(dec_op),
    .adr_size(dec_adr),
    .rex_fields(dec_rex)
  );

  oss_seg_select u_seg (
    .mode64(mode64),
    .ref_kind(ref_kind),
    .base_sp_bp(base_sp_bp),
    .ovr_valid(ovr_valid),
    .ovr_seg(ovr_seg),
    .bases(st_r.base),
    .seg(dec_seg),
    .seg_base(dec_base)
  );

  // offset trimmed to the address width, then segment base added
  always_comb begin
    case (dec_adr)
      oss_pkg::OSS_SZ16: ea_m = {48'h0, eff_addr[15:0]};
      oss_pkg::OSS_SZ32: ea_m = {32'h0, eff_addr[31:0]};
      default: ea_m = eff_addr;
    endcase
    lin = dec_base + ea_m;

    // legacy linear space wraps at 4 gbytes
    if (!mode64) begin
      lin = {32'h0, lin[31:0]};
    end
  end

  // register read value, zero outside the map
  function automatic logic [31:0] rd_word(input oss_state_s s, input logic [7:0] a);
    logic [7:0] rel;
    logic [2:0] k;
    rd_word = 32'h0;
    rel = a - oss_pkg::OSS_ADDR_BASE0;
    k = rel[5:3];

    if (a == oss_pkg::OSS_ADDR_CTRL) begin
      rd_word = s.ctrl;
    end else if (a == oss_pkg::OSS_ADDR_STATUS) begin
      rd_word = {21'h0, s.byte_bad, s.imm_bad, s.seg, s.rex_fields[oss_pkg::OSS_OPERAND_WIDTH_BIT_BIT],
        mode64, s.adr_size, s.op_size};
    end else if (a == oss_pkg::OSS_ADDR_COUNT) begin
      rd_word = s.count;
    end else if (a >= oss_pkg::OSS_ADDR_BASE0 && a < oss_pkg::OSS_ADDR_BASE_END) begin
      rd_word = rel[2] ? s.base[k][63:32] : s.base[k][31:0];
    end
  endfunction : rd_word

  // aligned and mapped words only
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a == oss_pkg::OSS_ADDR_CTRL ||
      a == oss_pkg::OSS_ADDR_STATUS || a == oss_pkg::OSS_ADDR_COUNT ||
      (a >= oss_pkg::OSS_ADDR_BASE0 && a < oss_pkg::OSS_ADDR_BASE_END));
  endfunction : addr_ok

  // byte-lane merge of a write into one word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : merge

  // ready is low while a write is held or its answer is pending
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;

  // next state: bus slave, register writes and decode stage
  always_comb begin
    logic [7:0] rel;
    logic [2:0] k;
    st_nxt = st_r;
    rel = st_r.aw_addr - oss_pkg::OSS_ADDR_BASE0;
    k = rel[5:3];

    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end

    // commit once both halves are held; status and count are read only
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_ok(st_r.aw_addr) ? oss_pkg::OSS_RESP_OKAY : oss_pkg::OSS_RESP_SLVERR;
      if (st_r.aw_addr == oss_pkg::OSS_ADDR_CTRL) begin
        st_nxt.ctrl = merge(st_r.ctrl, st_r.w_data, st_r.w_strb);
        st_nxt.ctrl[31:oss_pkg::OSS_CTRL_W] = '0;
      end else if (addr_ok(st_r.aw_addr) && st_r.aw_addr >= oss_pkg::OSS_ADDR_BASE0) begin
        if (rel[2]) begin
          st_nxt.base[k][63:32] = merge(st_r.base[k][63:32], st_r.w_data, st_r.w_strb);
        end else begin
          st_nxt.base[k][31:0] = merge(st_r.base[k][31:0], st_r.w_data, st_r.w_strb);
        end
      end
    end
    // answer stands until taken
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read answered the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word(st_r, s_axi_araddr);
      st_nxt.rresp = addr_ok(s_axi_araddr) ? oss_pkg::OSS_RESP_OKAY : oss_pkg::OSS_RESP_SLVERR;
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // all results of one instruction move together
    st_nxt.out_valid = in_valid;
    if (in_valid) begin
      st_nxt.count = st_r.count + 32'h1;
      st_nxt.op_size = dec_op;
      st_nxt.adr_size = dec_adr;
      st_nxt.rex_fields = dec_rex;
      st_nxt.seg = dec_seg;
      st_nxt.linear = lin;
      // divides take no immediate; the port caps it at 32 bits
      st_nxt.imm_bad = imm_valid && op_is_divide;
      // sign extended for 64-bit
      case (dec_op)
        oss_pkg::OSS_SZ16: st_nxt.imm_ext = {48'h0, imm[15:0]};
        oss_pkg::OSS_SZ32: st_nxt.imm_ext = {32'h0, imm};
        default: st_nxt.imm_ext = {{32{imm[31]}}, imm};
      endcase
      // high half from data-high, low half from accumulator
      if (mode64 && dec_op == oss_pkg::OSS_SZ64) begin
        st_nxt.pair = {data_high_register_wide, accumulator_register_wide};
      end else begin
        st_nxt.pair = {64'h0, data_high_register_wide[31:0],
          accumulator_register_wide[31:0]};
      end

      // halves as laid in memory
      st_nxt.far_ofs = far_ptr[31:0]; // first doubleword
      st_nxt.far_sel = far_ptr[47:32]; // following word

      // without the prefix, codes 4..7 name the high bytes of 0..3
      st_nxt.byte_bad = !rex_present && byte_reg[3];
      st_nxt.byte_hi = !rex_present && byte_reg[2] && !byte_reg[3];
      st_nxt.byte_idx = st_nxt.byte_hi ? {2'b00, byte_reg[1:0]} : byte_reg;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ctrl <= oss_pkg::OSS_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // decode results
  assign out_valid = st_r.out_valid;
  assign op_size = st_r.op_size;
  assign adr_size = st_r.adr_size;
  assign rex_fields = st_r.rex_fields;
  assign seg = st_r.seg;
  assign linear_addr = st_r.linear;
  assign imm_ext = st_r.imm_ext;
  assign imm_bad = st_r.imm_bad;
  assign pair_operand = st_r.pair;
  assign far_offset = st_r.far_ofs;
  assign far_selector = st_r.far_sel;
  assign byte_idx = st_r.byte_idx;
  assign byte_hi = st_r.byte_hi;
  assign byte_bad = st_r.byte_bad;

endmodule : oss_decode_top
`default_nettype wire

// File: oss_decode_top_properties.sv
// concurrent checks on the decode stage results
`timescale 1ns/1ps
`default_nettype none
module oss_decode_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  input wire logic has_opsz,
  input wire logic rex_present,
  input wire logic [3:0] rex_bits,
  input wire logic media_op,
  input wire oss_pkg::oss_ref_e ref_kind,
  input wire logic base_sp_bp,
  input wire logic ovr_valid,
  input wire logic [2:0] ovr_seg,
  input wire logic imm_valid,
  input wire logic op_is_divide,
  input wire logic [47:0] far_ptr,
  input wire logic out_valid,
  input wire oss_pkg::oss_size_e op_size,
  input wire oss_pkg::oss_size_e adr_size,
  input wire oss_pkg::oss_seg_e seg,
  input wire logic imm_bad,
  input wire logic [31:0] far_offset,
  input wire logic [15:0] far_selector
);
  logic w_seen;
  logic short_op;
  // adr_size of 64 only occurs in 64-bit mode, so it stands in for the hidden mode flag
  assign w_seen = rex_present && rex_bits[3];
  assign short_op = has_opsz && !media_op && !w_seen;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  out_pulse_a: assert property (in_valid |=> out_valid)
    else $error("no result pulse after an instruction");
  fetch_code_a: assert property (in_valid && ref_kind == oss_pkg::OSS_REF_FETCH |=>
    seg == oss_pkg::OSS_SEG_CODE) else $error("fetch not on code segment");
  stack_op_a: assert property (in_valid && ref_kind == oss_pkg::OSS_REF_STACK_OP |=>
    seg == oss_pkg::OSS_SEG_STACK) else $error("push or pop off stack segment");
  str_dst_a: assert property (in_valid && ref_kind == oss_pkg::OSS_REF_STR_DST |=>
    seg == oss_pkg::OSS_SEG_EXTRA) else $error("string target off extra segment");
  sp_base_a: assert property (in_valid && ref_kind == oss_pkg::OSS_REF_DATA &&
    base_sp_bp && !ovr_valid |=> seg == oss_pkg::OSS_SEG_STACK)
    else $error("stack based reference off stack segment");
  ovr_pick_a: assert property (in_valid && ref_kind == oss_pkg::OSS_REF_DATA &&
    ovr_valid && ovr_seg < 3'h6 |=> seg == $past(ovr_seg)) else $error("override ignored");
  far_split_a: assert property (in_valid |=>
    {far_selector, far_offset} == $past(far_ptr)) else $error("far pointer split wrong");
  width_wins_a: assert property (out_valid && adr_size == oss_pkg::OSS_SZ64 &&
    $past(w_seen) |-> op_size == oss_pkg::OSS_SZ64) else $error("width bit lost");
  prefix16_a: assert property (out_valid && adr_size == oss_pkg::OSS_SZ64 &&
    $past(short_op) |-> op_size == oss_pkg::OSS_SZ16) else $error("66 prefix not 16 bit");
  no_addr16_a: assert property (out_valid && op_size == oss_pkg::OSS_SZ64 |->
    adr_size != oss_pkg::OSS_SZ16) else $error("16 bit address in 64-bit mode");
  imm_div_a: assert property (in_valid |=>
    imm_bad == ($past(imm_valid) && $past(op_is_divide))) else $error("immediate flag wrong");
  cover property (out_valid && op_size == oss_pkg::OSS_SZ64);
  cover property (in_valid && ovr_valid && ref_kind == oss_pkg::OSS_REF_DATA);
  cover property (in_valid && imm_valid && op_is_divide);
endmodule : oss_decode_props
bind oss_decode_top oss_decode_props chk (.aclk(aclk), .aresetn(aresetn), .in_valid(in_valid),
  .has_opsz(has_opsz), .rex_present(rex_present), .rex_bits(rex_bits), .media_op(media_op),
  .ref_kind(ref_kind), .base_sp_bp(base_sp_bp), .ovr_valid(ovr_valid), .ovr_seg(ovr_seg),
  .imm_valid(imm_valid), .op_is_divide(op_is_divide), .far_ptr(far_ptr),
  .out_valid(out_valid), .op_size(op_size), .adr_size(adr_size), .seg(seg),
  .imm_bad(imm_bad), .far_offset(far_offset), .far_selector(far_selector));
`default_nettype wire

// File: oss_decode_top_tb.sv
// self-checking bench for the operand size and segment decode stage
`timescale 1ns/1ps
`default_nettype none
module oss_decode_top_tb;
  localparam oss_pkg::oss_size_e s16 = oss_pkg::OSS_SZ16;
  localparam oss_pkg::oss_size_e s32 = oss_pkg::OSS_SZ32;
  localparam oss_pkg::oss_size_e s64 = oss_pkg::OSS_SZ64;
  localparam logic [1:0] rok = oss_pkg::OSS_RESP_OKAY;
  localparam logic [1:0] rerr = oss_pkg::OSS_RESP_SLVERR;
  localparam oss_pkg::oss_ref_e rdat = oss_pkg::OSS_REF_DATA;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, imm = 32'h0;
  logic [3:0] wstrb = 4'hf, rex_bits = 4'h0, byte_reg = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, far_offset;
  logic in_valid = 1'b0, has_opsz = 1'b0, has_adsz = 1'b0, rex_present = 1'b0;
  logic media_op = 1'b0, base_sp_bp = 1'b0, ovr_valid = 1'b0;
  logic imm_valid = 1'b0, op_is_divide = 1'b0;
  oss_pkg::oss_ref_e ref_kind = oss_pkg::OSS_REF_DATA;
  logic [2:0] ovr_seg = 3'h0;
  logic [63:0] eff_addr = 64'h0, acc = 64'h0, dh = 64'h0, linear_addr, imm_ext;
  logic [47:0] far_ptr = 48'h0;
  logic out_valid, imm_bad, byte_hi, byte_bad;
  oss_pkg::oss_size_e op_size, adr_size;
  oss_pkg::oss_seg_e seg;
  logic [3:0] rex_fields, byte_idx;
  logic [127:0] pair_operand;
  logic [15:0] far_selector;
  int err_count = 0, check_count = 0, n_dec = 0;

  // design under test, every port wired
  oss_decode_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid),
    .has_opsz(has_opsz), .has_adsz(has_adsz), .rex_present(rex_present),
    .rex_bits(rex_bits), .media_op(media_op), .ref_kind(ref_kind), .base_sp_bp(base_sp_bp),
    .ovr_valid(ovr_valid), .ovr_seg(ovr_seg), .eff_addr(eff_addr), .imm_valid(imm_valid),
    .op_is_divide(op_is_divide), .imm(imm), .accumulator_register_wide(acc),
    .data_high_register_wide(dh), .far_ptr(far_ptr), .byte_reg(byte_reg),
    .out_valid(out_valid), .op_size(op_size), .adr_size(adr_size), .rex_fields(rex_fields),
    .seg(seg), .linear_addr(linear_addr), .imm_ext(imm_ext), .imm_bad(imm_bad),
    .pair_operand(pair_operand), .far_offset(far_offset), .far_selector(far_selector),
    .byte_idx(byte_idx), .byte_hi(byte_hi), .byte_bad(byte_bad));

  // 250 mhz core clock
  always #2 aclk = ~aclk;

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // ready is judged at the falling edge so the handshake edge never races the design
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_go, w_go, b_go;
    int n;
    n = 0;
    b_go = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_go && n < 100) begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      if (b_go) chk(bresp, er);
      @(posedge aclk);
      n++;
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(b_go, 1'b1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_go, r_go;
    int n;
    n = 0;
    r_go = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_go && n < 100) begin
      @(negedge aclk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      if (r_go) chk({rresp, rdata}, {er, ed});
      @(posedge aclk);
      n++;
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(r_go, 1'b1);
  endtask : axi_rd

  // one instruction, results looked at in the out_valid cycle
  task automatic issue(input logic o, a, rp, w, md, input oss_pkg::oss_ref_e rk,
                       input logic bsp, ov, input logic [2:0] os);
    @(posedge aclk);
    {has_opsz, has_adsz, rex_present, media_op} <= {o, a, rp, md};
    rex_bits <= {w, 3'b101};
    ref_kind <= rk;
    {base_sp_bp, ovr_valid, ovr_seg} <= {bsp, ov, os};
    in_valid <= 1'b1;
    @(posedge aclk);
    in_valid <= 1'b0;
    n_dec++;
    @(negedge aclk);
    chk(out_valid, 1'b1);
  endtask : issue

  task automatic t_regs;
    axi_rd(oss_pkg::OSS_ADDR_CTRL, oss_pkg::OSS_CTRL_RST, rok);
    axi_rd(8'hfc, 32'h0, rerr);
    axi_wr(8'hfc, 32'h1, 4'hf, rerr);
    axi_wr(8'h02, 32'h1, 4'hf, rerr);
    axi_wr(oss_pkg::OSS_ADDR_STATUS, 32'hffff_ffff, 4'hf, rok);
    axi_wr(oss_pkg::OSS_ADDR_CTRL, 32'hffff_ffff, 4'h0, rok);
    axi_rd(oss_pkg::OSS_ADDR_CTRL, 32'h0, rok);
    axi_wr(oss_pkg::OSS_ADDR_CTRL, 32'hffff_ffff, 4'hf, rok);
    axi_rd(oss_pkg::OSS_ADDR_CTRL, 32'h0000_000f, rok);
  endtask : t_regs

  // real, compat 16, compat 32, 64-bit; every 66 and 67 combination, extension prefix and width bit in 64-bit mode only
  task automatic t_sizes;
    logic [3:0] modes [4];
    logic m64, d;
    oss_pkg::oss_size_e eo, ea;
    modes = '{4'h0, 4'h9, 4'hd, 4'hb};
    for (int m = 0; m < 4; m++) begin
      axi_wr(oss_pkg::OSS_ADDR_CTRL, {28'h0, modes[m]}, 4'hf, rok);
      m64 = modes[m][0] && modes[m][1];
      d = modes[m][2] && modes[m][3];
      for (int i = 0; i < 8; i++) begin
        issue(i[0], i[1], m64, m64 && i[2], 1'b0, rdat, 1'b0, 1'b0, 3'h0);
        eo = m64 ? (i[2] ? s64 : (i[0] ? s16 : s32)) : ((i[0] ^ d) ? s32 : s16);
        ea = m64 ? (i[1] ? s32 : s64) : ((i[1] ^ d) ? s32 : s16);
        chk(op_size, eo);
        chk(adr_size, ea);
        chk(rex_fields, m64 ? {i[2], 3'b101} : 4'h0);
      end
    end
    issue(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, rdat, 1'b0, 1'b0, 3'h0);
    chk(op_size, s32);
    issue(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, rdat, 1'b0, 1'b0, 3'h0);
    chk(op_size, s64);
  endtask : t_sizes

  task automatic t_segs;
    for (int k = 0; k < 6; k++) begin
      issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b1, 1'b1, k[2:0]);
      chk(seg, k);
      issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, oss_pkg::OSS_REF_FETCH, 1'b1, 1'b1, k[2:0]);
      chk(seg, oss_pkg::OSS_SEG_CODE);
      issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, oss_pkg::OSS_REF_STACK_OP, 1'b0, 1'b1, k[2:0]);
      chk(seg, oss_pkg::OSS_SEG_STACK);
      issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, oss_pkg::OSS_REF_STR_DST, 1'b1, 1'b1, k[2:0]);
      chk(seg, oss_pkg::OSS_SEG_EXTRA);
    end
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b1, 1'b0, 3'h0);
    chk(seg, oss_pkg::OSS_SEG_STACK);
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b1, 3'h7);
    chk(seg, oss_pkg::OSS_SEG_DATA);
  endtask : t_segs

  // data base must vanish in 64-bit mode while the aux base still adds
  task automatic t_bases;
    axi_wr(8'h28, 32'h0000_1000, 4'hf, rok);
    axi_wr(8'h30, 32'h2000_0000, 4'hf, rok);
    axi_wr(8'h34, 32'h0000_0001, 4'hf, rok);
    axi_rd(8'h34, 32'h0000_0001, rok);
    @(posedge aclk);
    eff_addr <= 64'h0000_0000_8000_0010;
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b0, 3'h0);
    chk(linear_addr, 64'h0000_0000_8000_0010);
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b1, 3'h4);
    chk(linear_addr, 64'h0000_0001_a000_0010);
    axi_wr(oss_pkg::OSS_ADDR_CTRL, 32'hd, 4'hf, rok);
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b0, 3'h0);
    chk(linear_addr, 64'h0000_0000_8000_1010);
  endtask : t_bases

  task automatic t_misc;
    axi_wr(oss_pkg::OSS_ADDR_CTRL, 32'hb, 4'hf, rok);
    @(posedge aclk);
    acc <= 64'h1111_2222_3333_4444;
    dh <= 64'h5555_6666_7777_8888;
    far_ptr <= 48'hbeef_0123_4567;
    {byte_reg, imm_valid, op_is_divide, imm} <= {4'h9, 1'b1, 1'b1, 32'hffff_ffff};
    issue(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, rdat, 1'b0, 1'b0, 3'h0);
    chk(pair_operand, {dh, acc});
    chk({far_selector, far_offset}, 48'hbeef_0123_4567);
    chk({imm_bad, byte_bad, imm_ext}, {2'b10, ~64'h0});
    @(posedge aclk);
    op_is_divide <= 1'b0;
    issue(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b0, 3'h0);
    chk(pair_operand, {64'h0, dh[31:0], acc[31:0]});
    chk({imm_bad, byte_bad, imm_ext}, {2'b01, 64'hffff_ffff});
    @(posedge aclk);
    byte_reg <= 4'h6;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, rdat, 1'b0, 1'b0, 3'h0);
    chk({byte_hi, byte_idx, imm_ext}, {5'h12, 64'hffff});
    axi_rd(oss_pkg::OSS_ADDR_STATUS, 32'hd8, rok);
  endtask : t_misc

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chk(out_valid, 1'b0);
    t_regs;
    t_sizes;
    t_segs;
    t_bases;
    t_misc;
    axi_rd(oss_pkg::OSS_ADDR_COUNT, n_dec, rok);
    print_verdict;
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict;
  end
endmodule : oss_decode_top_tb
`default_nettype wire
